/* src/fses_host.sv */
// The APB slave port and the register addresses were left to the implementer.
`timescale 1ns/10ps
module fses_host #(
  parameter logic [15:0] RPH_CYCLES = 16'(fses_pkg::RPH_CYC)
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        clk_en,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // flash pins
  output logic      [25:0] fl_addr,
  output logic      [15:0] fl_dq_out,
  output logic             fl_dq_oe,
  input  wire logic [15:0] fl_dq_in,
  output logic             fl_ce_n,
  output logic             fl_oe_n,
  output logic             fl_we_n,
  output logic             fl_rst_n
);

  // ------------------------------------------------------------
  // command sequence tables
  // ------------------------------------------------------------
  function automatic logic [3:0] seq_len(input fses_pkg::fses_op_t op);
    seq_len = 4'h1;
    if (op == fses_pkg::OP_CERASE || op == fses_pkg::OP_SERASE) begin
      seq_len = fses_pkg::ERASE_STEPS;
    end
  endfunction

  function automatic logic [9:0] seq_ent(input fses_pkg::fses_op_t op,
                                         input logic [3:0] step);
    seq_ent = {fses_pkg::AK_TGT, fses_pkg::CMD_STATUS};
    case (op)
      fses_pkg::OP_STATUS: seq_ent = {fses_pkg::AK_555, fses_pkg::CMD_STATUS};
      fses_pkg::OP_PSUSP:  seq_ent = {fses_pkg::AK_TGT, fses_pkg::CMD_PSUSP};
      fses_pkg::OP_PRES:   seq_ent = {fses_pkg::AK_TGT, fses_pkg::CMD_PRES};
      fses_pkg::OP_ESUSP:  seq_ent = {fses_pkg::AK_TGT, fses_pkg::CMD_ESUSP};
      fses_pkg::OP_ERES:   seq_ent = {fses_pkg::AK_TGT, fses_pkg::CMD_ERES};
      fses_pkg::OP_BLANK:  seq_ent = {fses_pkg::AK_SEC555, fses_pkg::CMD_BLANK};
      fses_pkg::OP_CERASE, fses_pkg::OP_SERASE: begin
        case (step)
          4'h0, 4'h3: seq_ent = {fses_pkg::AK_555, fses_pkg::CMD_UNLOCK1};
          4'h1, 4'h4: seq_ent = {fses_pkg::AK_2AA, fses_pkg::CMD_UNLOCK2};
          4'h2:       seq_ent = {fses_pkg::AK_555, fses_pkg::CMD_SETUP};
          default: begin
            if (op == fses_pkg::OP_CERASE) begin
              seq_ent = {fses_pkg::AK_555, fses_pkg::CMD_CHIP};
            end else begin
              seq_ent = {fses_pkg::AK_TGT, fses_pkg::CMD_SECTOR};
            end
          end
        endcase
      end
      default: seq_ent = {fses_pkg::AK_TGT, fses_pkg::CMD_STATUS};
    endcase
  endfunction

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  fses_pkg::fses_state_t state, next_state;
  fses_pkg::fses_op_t    op, next_op;
  logic [3:0]  step, next_step;
  logic [15:0] cnt, next_cnt;
  logic [15:0] pbs_cnt, next_pbs_cnt;
  logic [25:0] tgt, next_tgt;
  logic [7:0]  sr, next_sr;
  logic        erasing, next_erasing;
  logic        chip, next_chip;
  logic        esusp, next_esusp;
  logic        psusp, next_psusp;
  logic        refused, next_refused;
  logic [31:0] next_prdata;
  logic        next_pready, next_pslverr;
  logic [25:0] next_fl_addr;
  logic [15:0] next_fl_dq_out;
  logic        next_fl_dq_oe, next_fl_ce_n, next_fl_oe_n, next_fl_we_n;
  logic        next_fl_rst_n;
  logic [15:0] dq_meta, dq_sync;

  // ------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------
  logic                 acc, hit;
  fses_pkg::fses_op_t   req;
  logic                 deny;
  logic [9:0]           ent;

  always_comb begin
    acc = psel & penable & pready;
    hit = (paddr == fses_pkg::OFF_CTRL) | (paddr == fses_pkg::OFF_ADDR) |
          (paddr == fses_pkg::OFF_STAT);
    req = fses_pkg::fses_op_t'(pwdata[3:0]);
    next_state = state;  next_op = op;  next_step = step;  next_cnt = cnt;
    next_tgt = tgt;  next_sr = sr;  next_erasing = erasing;  next_chip = chip;
    next_esusp = esusp;  next_psusp = psusp;  next_refused = refused;
    next_fl_addr = fl_addr;  next_fl_dq_out = fl_dq_out;
    next_fl_dq_oe = fl_dq_oe;  next_fl_ce_n = fl_ce_n;  next_fl_oe_n = fl_oe_n;
    next_fl_we_n = fl_we_n;  next_fl_rst_n = fl_rst_n;
    next_pbs_cnt = (pbs_cnt != 16'h0000) ? pbs_cnt - 16'h0001 : pbs_cnt;
    // overlay spaces are never entered here, so suspends never meet one
    case (req)
      fses_pkg::OP_STATUS: deny = 1'b0;
      fses_pkg::OP_HWRST:  deny = 1'b0;
      fses_pkg::OP_PSUSP:  deny = psusp | (erasing & ~esusp) |
                                  (pbs_cnt != 16'h0000);
      fses_pkg::OP_PRES:   deny = ~psusp;
      fses_pkg::OP_ESUSP:  deny = ~erasing | chip | esusp;
      fses_pkg::OP_ERES:   deny = ~esusp | psusp;
      fses_pkg::OP_BLANK, fses_pkg::OP_CERASE,
      fses_pkg::OP_SERASE: deny = erasing | esusp | psusp;
      default:             deny = 1'b1;
    endcase
    ent = seq_ent(op, step);
    case (fses_pkg::fses_ak_t'(ent[9:8]))
      fses_pkg::AK_555: next_fl_addr = fses_pkg::ADDR_555;
      fses_pkg::AK_2AA: next_fl_addr = fses_pkg::ADDR_2AA;
      fses_pkg::AK_SEC555: next_fl_addr = {tgt[25:fses_pkg::SECTOR_BITS],
        fses_pkg::ADDR_555[fses_pkg::SECTOR_BITS-1:0]};
      default: next_fl_addr = tgt;
    endcase
    if (state == fses_pkg::ST_IDLE || state == fses_pkg::ST_RD ||
        state == fses_pkg::ST_RLO || state == fses_pkg::ST_RREC) begin
      next_fl_addr = fl_addr;
    end
    if (acc && pwrite && paddr == fses_pkg::OFF_ADDR) begin
      next_tgt = pwdata[25:0];
    end
    // refusal set wins over a clear; both cannot meet in one access anyway
    if (acc && pwrite && paddr == fses_pkg::OFF_STAT &&
        pwdata[fses_pkg::STAT_REFUSED]) begin
      next_refused = 1'b0;
    end
    if (acc && pwrite && paddr == fses_pkg::OFF_CTRL) begin
      if (state != fses_pkg::ST_IDLE || deny) begin
        next_refused = 1'b1;
      end else if (req == fses_pkg::OP_HWRST) begin
        next_op = req;
        next_state = fses_pkg::ST_RLO;
        next_fl_rst_n = 1'b0;
        next_cnt = fses_pkg::RST_LOW_CYC - 16'h0001;
      end else begin
        next_op = req;
        next_step = 4'h0;
        next_state = fses_pkg::ST_WHI;
        next_cnt = 16'h0000;
      end
    end
    case (state)
      fses_pkg::ST_WLO: begin
        if (cnt == 16'h0000) begin
          next_fl_we_n = 1'b1;
          next_state = fses_pkg::ST_WHI;
          next_cnt = fses_pkg::WE_HIGH_CYC - 16'h0001;
        end else begin
          next_cnt = cnt - 16'h0001;
        end
      end
      fses_pkg::ST_WHI: begin
        // entered once with step 0 as a launch before the first strobe
        if (cnt != 16'h0000) begin
          next_cnt = cnt - 16'h0001;
        end else if (fl_we_n && fl_ce_n) begin
          next_fl_ce_n = 1'b0;
          next_fl_we_n = 1'b0;
          next_fl_dq_oe = 1'b1;
          next_fl_dq_out = {8'h00, ent[7:0]};
          next_state = fses_pkg::ST_WLO;
          next_cnt = fses_pkg::WE_LOW_CYC - 16'h0001;
        end else if (step + 4'h1 < seq_len(op)) begin
          next_step = step + 4'h1;
          next_fl_ce_n = 1'b1;
        end else if (op == fses_pkg::OP_STATUS) begin
          next_fl_dq_oe = 1'b0;
          next_fl_oe_n = 1'b0;
          next_state = fses_pkg::ST_RD;
          next_cnt = fses_pkg::RD_CYC - 16'h0001;
        end else begin
          next_fl_ce_n = 1'b1;
          next_fl_dq_oe = 1'b0;
          next_state = fses_pkg::ST_IDLE;
          case (op)
            fses_pkg::OP_CERASE: begin
              next_erasing = 1'b1;
              next_chip = 1'b1;
            end
            fses_pkg::OP_SERASE: next_erasing = 1'b1;
            fses_pkg::OP_ESUSP:  next_esusp = 1'b1;
            fses_pkg::OP_ERES:   next_esusp = 1'b0;
            fses_pkg::OP_PSUSP:  next_psusp = 1'b1;
            fses_pkg::OP_PRES: begin
              next_psusp = 1'b0;
              next_pbs_cnt = fses_pkg::PBS_CYC;
            end
            default: next_erasing = erasing;
          endcase
        end
      end
      fses_pkg::ST_RD: begin
        if (cnt == 16'h0000) begin
          next_sr = dq_sync[7:0];
          next_fl_oe_n = 1'b1;
          next_fl_ce_n = 1'b1;
          next_state = fses_pkg::ST_IDLE;
          // ready with nothing suspended: erase (or blank check) is over
          if (dq_sync[fses_pkg::SR_READY_BIT] && !esusp && !psusp) begin
            next_erasing = 1'b0;
            next_chip = 1'b0;
          end
        end else begin
          next_cnt = cnt - 16'h0001;
        end
      end
      fses_pkg::ST_RLO: begin
        if (cnt == 16'h0000) begin
          next_fl_rst_n = 1'b1;
          next_state = fses_pkg::ST_RREC;
          next_cnt = RPH_CYCLES;
        end else begin
          next_cnt = cnt - 16'h0001;
        end
      end
      fses_pkg::ST_RREC: begin
        if (cnt == 16'h0000) begin
          // erase is gone; software must start it over
          next_erasing = 1'b0;
          next_chip = 1'b0;
          next_esusp = 1'b0;
          next_psusp = 1'b0;
          next_state = fses_pkg::ST_IDLE;
        end else begin
          next_cnt = cnt - 16'h0001;
        end
      end
      default: next_state = next_state;
    endcase
    // apb: no wait state, data launched from the setup cycle
    next_pready = psel & ~penable;
    next_pslverr = psel & ~penable & ~hit;
    next_prdata = 32'h00000000;
    if (psel && !penable && !pwrite) begin
      case (paddr)
        fses_pkg::OFF_CTRL: next_prdata = {28'h0000000, op};
        fses_pkg::OFF_ADDR: next_prdata = {6'h00, tgt};
        fses_pkg::OFF_STAT: next_prdata = {16'h0000, sr, 1'b0,
          pbs_cnt != 16'h0000, refused, psusp, esusp, chip, erasing,
          state != fses_pkg::ST_IDLE};
        default: next_prdata = 32'h00000000;
      endcase
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state <= fses_pkg::ST_IDLE;  op <= fses_pkg::OP_STATUS;
      step <= 4'h0;  cnt <= 16'h0000;  pbs_cnt <= 16'h0000;
      tgt <= 26'h0000000;  sr <= 8'h00;  erasing <= 1'b0;  chip <= 1'b0;
      esusp <= 1'b0;  psusp <= 1'b0;  refused <= 1'b0;
      prdata <= 32'h00000000;  pready <= 1'b0;  pslverr <= 1'b0;
      fl_addr <= 26'h0000000;  fl_dq_out <= 16'h0000;  fl_dq_oe <= 1'b0;
      fl_ce_n <= 1'b1;  fl_oe_n <= 1'b1;  fl_we_n <= 1'b1;  fl_rst_n <= 1'b1;
      dq_meta <= 16'h0000;  dq_sync <= 16'h0000;
    end else if (clk_en) begin
      state <= next_state;  op <= next_op;  step <= next_step;
      cnt <= next_cnt;  pbs_cnt <= next_pbs_cnt;  tgt <= next_tgt;
      sr <= next_sr;  erasing <= next_erasing;  chip <= next_chip;
      esusp <= next_esusp;  psusp <= next_psusp;  refused <= next_refused;
      prdata <= next_prdata;  pready <= next_pready;  pslverr <= next_pslverr;
      fl_addr <= next_fl_addr;  fl_dq_out <= next_fl_dq_out;
      fl_dq_oe <= next_fl_dq_oe;  fl_ce_n <= next_fl_ce_n;
      fl_oe_n <= next_fl_oe_n;  fl_we_n <= next_fl_we_n;
      fl_rst_n <= next_fl_rst_n;
      dq_meta <= fl_dq_in;
      dq_sync <= dq_meta;
    end
  end

endmodule // fses_host

/* src/fses_pkg.sv */
package fses_pkg;

  // ------------------------------------------------------------
  // register map (byte offsets)
  // ------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_ADDR = 8'h04;
  localparam logic [7:0] OFF_STAT = 8'h08;

  localparam int STAT_BUSY    = 0;
  localparam int STAT_ERASING = 1;
  localparam int STAT_CHIP    = 2;
  localparam int STAT_ESUSP   = 3;
  localparam int STAT_PSUSP   = 4;
  localparam int STAT_REFUSED = 5;
  localparam int STAT_PBSWAIT = 6;
  localparam int STAT_SRLO    = 8;
  localparam int SR_READY_BIT = 7;

  typedef enum logic [3:0] {
    OP_STATUS = 4'h0,
    OP_PSUSP  = 4'h1,
    OP_PRES   = 4'h2,
    OP_ESUSP  = 4'h3,
    OP_ERES   = 4'h4,
    OP_BLANK  = 4'h5,
    OP_CERASE = 4'h6,
    OP_SERASE = 4'h7,
    OP_HWRST  = 4'h8
  } fses_op_t;

  // ------------------------------------------------------------
  // flash command codes
  // ------------------------------------------------------------
  localparam logic [7:0] CMD_UNLOCK1 = 8'hAA;
  localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
  localparam logic [7:0] CMD_SETUP   = 8'h80;
  localparam logic [7:0] CMD_CHIP    = 8'h10;
  localparam logic [7:0] CMD_SECTOR  = 8'h30;
  localparam logic [7:0] CMD_ERES    = 8'h30;
  localparam logic [7:0] CMD_ESUSP   = 8'hB0;
  localparam logic [7:0] CMD_PSUSP   = 8'h51;
  localparam logic [7:0] CMD_PRES    = 8'h50;
  localparam logic [7:0] CMD_BLANK   = 8'h33;
  localparam logic [7:0] CMD_STATUS  = 8'h70;

  typedef enum logic [1:0] {
    AK_555    = 2'h0,
    AK_2AA    = 2'h1,
    AK_TGT    = 2'h2,
    AK_SEC555 = 2'h3
  } fses_ak_t;

  localparam logic [25:0] ADDR_555    = 26'h0000555;
  localparam logic [25:0] ADDR_2AA    = 26'h00002AA;
  localparam int          SECTOR_BITS = 16;
  localparam logic [3:0]  ERASE_STEPS = 4'h6;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_NS      = 4;
  localparam int WE_LOW_NS   = 50;
  localparam int WE_HIGH_NS  = 20;
  localparam int RD_NS       = 100;
  localparam int RST_LOW_NS  = 500;
  localparam int RPH_NS      = 50000;
  localparam int PBS_NS      = 5000;

  localparam logic [15:0] WE_LOW_CYC  = 16'((WE_LOW_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [15:0] WE_HIGH_CYC = 16'((WE_HIGH_NS + CLK_NS - 1) / CLK_NS);
  // two extra cycles cover the input synchroniser
  localparam logic [15:0] RD_CYC = 16'((RD_NS + CLK_NS - 1) / CLK_NS + 2);
  localparam logic [15:0] RST_LOW_CYC = 16'((RST_LOW_NS + CLK_NS - 1) / CLK_NS);
  localparam int          RPH_CYC = (RPH_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [15:0] PBS_CYC = 16'((PBS_NS + CLK_NS - 1) / CLK_NS);

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_WLO  = 3'h1,
    ST_WHI  = 3'h2,
    ST_RD   = 3'h3,
    ST_RLO  = 3'h4,
    ST_RREC = 3'h5
  } fses_state_t;

endpackage

/* bench/fses_flash_model.sv */
`timescale 1ns/10ps
module fses_flash_model #(
  parameter int BUSY_READS = 2
) (
  // flash pins seen from the device side
  input wire logic [25:0] fl_addr,
  input wire logic [15:0] fl_dq_out,
  input wire logic        fl_ce_n, fl_oe_n, fl_we_n, fl_rst_n,
  output logic     [15:0] dq
);
  int          cnt = 0;
  bit          esusp, psusp, chip, bfail;
  logic [7:0]  last = 8'h00;
  logic [15:0] held = 16'h0000;
  // ----------------
  // command decode, suspend latency taken as zero
  // ----------------
  always @(posedge fl_we_n or negedge fl_rst_n) begin
    if (!fl_rst_n) begin
      {esusp, psusp, chip, bfail} = 4'h0;
      cnt = 0;
    end else if (!fl_ce_n) begin
      case (fl_dq_out[7:0])
        8'h10: if (last == 8'h55 && cnt == 0) begin
          chip = 1'b1;
          cnt = BUSY_READS;
        end
        8'h30: if (esusp || (last == 8'h55 && cnt == 0)) begin
          esusp = 1'b0;
          cnt = BUSY_READS;
        end
        8'hB0: if (cnt > 0 && !chip) esusp = 1'b1;
        8'h51: psusp = 1'b1;
        8'h50: psusp = 1'b0;
        // blank check only counts at word 555h of a sector
        8'h33: if (cnt == 0 && !esusp && !psusp &&
                   fl_addr[15:0] == 16'h0555) begin
          bfail = 1'b1;
          cnt = BUSY_READS;
        end
        default: ; // ignored
      endcase
      last = fl_dq_out[7:0];
    end
  end
  // each status read ages the running operation by one step
  always @(negedge fl_oe_n) begin
    if (!fl_ce_n) begin
      held = {8'h00, (cnt == 0 || esusp || psusp), 1'b0, bfail, 5'h00};
      if (cnt > 0 && !esusp && !psusp) cnt--;
      if (cnt == 0) chip = 1'b0;
    end
  end
  // a released bus shows the inverse, never a stale match
  assign dq = (!fl_ce_n && !fl_oe_n) ? held : ~held;
endmodule // fses_flash_model

/* bench/fses_host_properties.sv */
`timescale 1ns/10ps
module fses_host_properties #(
  parameter logic [15:0] RPH_CYCLES = 16'h0014
) (
  // clock, reset and apb
  input wire logic        clk_sys, sys_rst, clk_en, psel, penable, pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata, prdata,
  input wire logic        pready, pslverr,
  // flash pins
  input wire logic [25:0] fl_addr,
  input wire logic [15:0] fl_dq_out, fl_dq_in,
  input wire logic        fl_dq_oe, fl_ce_n, fl_oe_n, fl_we_n, fl_rst_n
);
  // ----------------
  // reset pulse length, counted since it exceeds a repetition
  // ----------------
  logic [7:0] rst_cnt, next_rst_cnt;
  always_comb next_rst_cnt = fl_rst_n ? 8'h00 : rst_cnt + 8'h01;
  always_ff @(posedge clk_sys or posedge sys_rst)
    if (sys_rst) rst_cnt <= 8'h00;
    else rst_cnt <= next_rst_cnt;
  // recovery window after the reset pulse, too long for a repetition
  logic [15:0] rec_cnt, next_rec_cnt;
  always_comb next_rec_cnt = !fl_rst_n ? RPH_CYCLES :
    (rec_cnt != 16'h0000) ? rec_cnt - 16'h0001 : rec_cnt;
  always_ff @(posedge clk_sys or posedge sys_rst)
    if (sys_rst) rec_cnt <= 16'h0000;
    else rec_cnt <= next_rec_cnt;
  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  a_apb_answer: assert property (psel && !penable && clk_en |=> pready)
    else $error("no answer after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_slverr_map: assert property (pready |->
    pslverr == !(paddr inside {8'h00, 8'h04, 8'h08}))
    else $error("slave error wrong");
  a_we_low_time: assert property ($fell(fl_we_n) |->
    (!fl_we_n)[*8] ##5 !fl_we_n ##1 fl_we_n) else $error("write width");
  a_read_time: assert property ($fell(fl_oe_n) |->
    ##26 !fl_oe_n ##1 fl_oe_n) else $error("read width");
  a_rst_pulse: assert property ($rose(fl_rst_n) |->
    rst_cnt inside {[8'h7C:8'h7E]}) else $error("reset pulse width");
  a_quiet_reset: assert property (!fl_rst_n |->
    fl_ce_n && fl_we_n && fl_oe_n) else $error("strobe during reset");
  a_rec_quiet: assert property (rec_cnt != 16'h0000 |->
    fl_ce_n) else $error("access during reset recovery");
  a_no_contention: assert property (!fl_oe_n |->
    !fl_dq_oe && fl_we_n) else $error("bus fight");
  a_cmd_steady: assert property (!fl_we_n && !$fell(fl_we_n) |->
    $stable(fl_addr) && $stable(fl_dq_out) && fl_dq_oe && !fl_ce_n
    && fl_dq_out[15:8] == 8'h00) else $error("command moved");
  c_esusp: cover property (!fl_we_n && fl_dq_out[7:0] == 8'hB0);
  c_chip: cover property (!fl_we_n && fl_dq_out[7:0] == 8'h10);
  c_blank: cover property (!fl_we_n && fl_dq_out[7:0] == 8'h33);
endmodule // fses_host_properties

bind fses_host fses_host_properties #(.RPH_CYCLES(RPH_CYCLES))
  i_fses_host_properties (.clk_sys, .sys_rst, .clk_en, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .fl_addr,
  .fl_dq_out, .fl_dq_in, .fl_dq_oe, .fl_ce_n, .fl_oe_n, .fl_we_n,
  .fl_rst_n);

/* bench/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  localparam logic [25:0] SA = 26'h1234567;
  logic        clk_sys = 1'b0, sys_rst = 1'b1, clk_en = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, q;
  logic        pready, pslverr, err, fl_dq_oe, fl_ce_n, fl_oe_n, fl_we_n;
  logic        fl_rst_n;
  logic [25:0] fl_addr;
  logic [15:0] fl_dq_out, fl_dq_in, dev_dq;
  logic [41:0] seen[$];
  int          num_errors = 0, tests_run = 0;
  assign fl_dq_in = fl_dq_oe ? fl_dq_out : dev_dq;
  fses_host #(.RPH_CYCLES(16'h0014)) i_fses_host (.clk_sys, .sys_rst,
    .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .fl_addr, .fl_dq_out, .fl_dq_oe, .fl_dq_in, .fl_ce_n,
    .fl_oe_n, .fl_we_n, .fl_rst_n);
  fses_flash_model i_fses_flash_model (.fl_addr, .fl_dq_out, .fl_ce_n,
    .fl_oe_n, .fl_we_n, .fl_rst_n, .dq(dev_dq));
  initial forever #2 clk_sys = ~clk_sys;
  always @(posedge fl_we_n) if (!fl_ce_n) seen.push_back({fl_addr, fl_dq_out});
  // ----------------
  // bus and compare helpers
  // ----------------
  task automatic check(input logic [41:0] got, input logic [41:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h, want %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    // no local limit: only the watchdog may end this wait
    while (pready !== 1'b1) @(posedge clk_sys);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic stat();
    apb(1'b0, fses_pkg::OFF_STAT, 32'h0000_0000);
  endtask
  // issue one order and poll until the controller is idle again
  task automatic op(input logic [3:0] c);
    apb(1'b1, fses_pkg::OFF_CTRL, {28'h0000000, c});
    stat();
    while (q[0] !== 1'b0) stat();
  endtask
  task automatic ewr(input logic [25:0] a, input logic [7:0] d);
    logic [41:0] got;
    got = (seen.size() > 0) ? seen.pop_front() : 42'h0;
    check(got, {a, 8'h00, d});
  endtask
  task automatic head();
    ewr(26'h555, 8'hAA);
    ewr(26'h2AA, 8'h55);
    ewr(26'h555, 8'h80);
    ewr(26'h555, 8'hAA);
    ewr(26'h2AA, 8'h55);
  endtask
  // a refused order sends nothing and flags itself, then the flag is cleared
  task automatic refused();
    check(42'(seen.size()), 42'h0);
    check(42'(q[5]), 42'h1);
    apb(1'b1, fses_pkg::OFF_STAT, 32'h0000_0020);
  endtask
  task automatic poll3();
    repeat (3) begin
      op(4'h0);
      ewr(26'h555, 8'h70);
    end
  endtask
  // ----------------
  // scenarios
  // ----------------
  task automatic t_reset();
    stat();
    check(42'(q), 42'h0);
    check(42'({fl_ce_n, fl_oe_n, fl_we_n, fl_rst_n, fl_dq_oe}), 42'h1E);
    apb(1'b0, 8'h0C, 32'h0000_0000);
    check(42'({err, q}), 42'h1_0000_0000);
    // a low clock enable must hold a just-accepted order before its strobe
    apb(1'b1, fses_pkg::OFF_CTRL, 32'h0000_0000);
    clk_en <= 1'b0;
    repeat (30) @(posedge clk_sys);
    check(42'({fl_ce_n, fl_we_n, fl_oe_n}), 42'h7);
    clk_en <= 1'b1;
    stat();
    while (q[0] !== 1'b0) stat();
    ewr(26'h555, 8'h70);
    check(42'(seen.size()), 42'h0);
  endtask
  task automatic t_sector();
    apb(1'b1, fses_pkg::OFF_ADDR, 32'h0123_4567);
    apb(1'b0, fses_pkg::OFF_ADDR, 32'h0000_0000);
    check(42'(q), 42'h0123_4567);
    op(4'h7);
    head();
    ewr(SA, 8'h30);
    check(42'(q[1]), 42'h1);
  endtask
  task automatic t_suspend();
    op(4'h3);
    ewr(SA, 8'hB0);
    check(42'(q[3]), 42'h1);
    op(4'h5);
    refused();
    op(4'h1);
    ewr(SA, 8'h51);
    check(42'(q[4:3]), 42'h3);
    op(4'h4);
    refused();
    op(4'h2);
    ewr(SA, 8'h50);
    check(42'(q[6]), 42'h1);
    op(4'h2);
    refused();
    op(4'h1);
    refused();
    op(4'h4);
    ewr(SA, 8'h30);
    op(4'h4);
    refused();
    poll3();
    check(42'({q[15:8], q[1]}), 42'h100);
  endtask
  task automatic t_chip();
    op(4'h6);
    head();
    ewr(26'h555, 8'h10);
    check(42'(q[2:1]), 42'h3);
    op(4'h3);
    refused();
    op(4'h8);
    check(42'({seen.size() > 0, q[4:0]}), 42'h0);
  endtask
  task automatic t_blank();
    apb(1'b1, fses_pkg::OFF_ADDR, 32'h02AB_1234);
    op(4'h5);
    ewr(26'h2AB0555, 8'h33);
    poll3();
    check(42'(q[15:8]), 42'hA0);
  endtask
  task automatic complete_run();
    $display("errors %0d of %0d checks", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_reset();
    t_sector();
    t_suspend();
    t_chip();
    t_blank();
    complete_run();
  end
  // the whole run needs well under 10k cycles; allow 50k
  initial begin
    #200000;
    num_errors++;
    complete_run();
  end
endmodule // tb_top
